// ==== hdl/poc_clock_ctrl.sv ====
// Clock generation control: multiplier, oscillator control, dividers
//
// Notes on behaviour
// [R1] Multiplier output runs eight times its reference
// [R2] System clock from multiplier is at most 50 MHz
// [R3] Speed field selects full, 50 or 25 MHz
// [R4] Software keeps system clock below pulse clock
// [R5] Multiplier enabled whenever power control operates
// [R6] Multiplier runs only with power and enable
// [R7] Lock status bit reads multiplier lock
// [R8] ADC clock select: 0 is 10, 1 is 5 MHz
// [R9] Divider field selects reference clock output rate; here it follows the system_clock_source input instead
// [R10] Slow trim: 0000 highest, 1111 lowest frequency
// [R11] Fast oscillator enable bit, resets to zero
// [R12] Fast ready flag shows oscillator at frequency
// [R13] Fast divider: 000 by 128 to 111 by 1
// [R14] Seven-bit calibration, reset to factory value
// [R15] Slow divider: 8, 4, 2, 1 for codes
// [R16] Suspend stops fast oscillator until wake event
// [R17] Source switchable; missing selected clock raises reset
// [R18] Reference select: 0 internal, 1 external clock
// [R19] Slow ready bit; reserved bit held zero
`timescale 1ns/10ps
`default_nettype none
module poc_clock_ctrl #(
  parameter int MULT_SETTLE = poc_pkg::MULT_SETTLE_CYC,
  parameter int OSC_START   = poc_pkg::OSC_START_CYC
) (
  input  wire logic           clk_sys,
  input  wire logic           rst,
  input  wire logic           ce,
  input  wire poc_pkg::poc_req_s req,
  output var  logic [7:0]     rdata,
  input  wire logic [1:0]     system_clock_source,
  input  wire logic           missing_det_enable,
  input  wire logic           ext_clock_present,
  input  wire logic           cmp_enabled,
  input  wire logic           cmp_out,
  input  wire logic           uart_rx,
  output var  logic           multiplier_run,
  output var  logic [3:0]     multiplier_factor,
  output var  logic           multiplier_ref_select,
  output var  logic [1:0]     pulse_gen_speed,
  output var  logic [3:0]     pulse_gen_div,
  output var  logic [2:0]     sys_from_mult_div,
  output var  logic [3:0]     loop_adc_div,
  output var  logic [1:0]     ref_out_divider,
  output var  logic [3:0]     ref_out_div_ratio,
  output var  logic           fast_osc_run,
  output var  logic [6:0]     fast_osc_calibration,
  output var  logic [7:0]     fast_osc_div_ratio,
  output var  logic           slow_osc_run,
  output var  logic [3:0]     slow_osc_trim,
  output var  logic [3:0]     slow_osc_div_ratio,
  output var  logic           power_ctrl_clock_ok,
  output var  logic           missing_clock_reset
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic       slow_en_r;
  logic [3:0] slow_trim_r;
  logic [1:0] slow_div_r;
  logic       fast_en_r;
  logic       suspend_r;
  logic [2:0] fast_div_r;
  logic [6:0] fast_cal_r;
  logic       mult_pwr_r;
  logic       mult_en_r;
  logic [1:0] speed_r;
  logic       adc_sel_r;
  logic       ref_sel_r;
  logic [1:0] ref_div_r;
  logic       rx_s1_r;
  logic       rx_s2_r;
  logic       rx_s3_r;
  logic       cmp_s1_r;
  logic       cmp_s2_r;
  logic       ext_s1_r;
  logic       ext_s2_r;
  logic       slow_ready;
  logic       fast_ready;
  logic       mult_locked;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input poc_pkg::poc_req_s r, input logic [7:0] off);
    hit = (r.addr == off);
  endfunction

  wire wr_slow = ce && req.wr && hit(req, poc_pkg::OFF_SLOW_OSC_CTRL);
  wire wr_fctl = ce && req.wr && hit(req, poc_pkg::OFF_FAST_OSC_CTRL);
  wire wr_ftrm = ce && req.wr && hit(req, poc_pkg::OFF_FAST_OSC_TRIM);
  wire wr_mult = ce && req.wr && hit(req, poc_pkg::OFF_MULT_CTRL);

  // Wake events for suspend: comparator low while enabled, or receive falling edge
  wire rx_fall = rx_s3_r && !rx_s2_r;                                // R16
  wire wake    = (cmp_enabled && !cmp_s2_r) || rx_fall;              // R16
  wire suspend_set = wr_fctl && req.wdata[poc_pkg::FAST_SUSP_BIT];

  // Running oscillators and multiplier
  wire fast_run_w = fast_en_r && !suspend_r;                         // R11 R16
  wire ref_ok     = ref_sel_r ? ext_s2_r : fast_run_w;               // R18
  wire mult_run_w = mult_pwr_r && mult_en_r && ref_ok;               // R6

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_s1_r  <= 1'b1;
      rx_s2_r  <= 1'b1;
      rx_s3_r  <= 1'b1;
      cmp_s1_r <= 1'b1;
      cmp_s2_r <= 1'b1;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
    end else if (ce) begin
      rx_s1_r  <= uart_rx;
      rx_s2_r  <= rx_s1_r;
      rx_s3_r  <= rx_s2_r;
      cmp_s1_r <= cmp_out;
      cmp_s2_r <= cmp_s1_r;
      ext_s1_r <= ext_clock_present;
      ext_s2_r <= ext_s1_r;
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  // Slow oscillator control
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      slow_en_r   <= poc_pkg::RST_SLOW_OSC_CTRL[poc_pkg::SLOW_EN_BIT];
      slow_trim_r <= poc_pkg::RST_SLOW_OSC_CTRL[5:2];
      slow_div_r  <= poc_pkg::RST_SLOW_OSC_CTRL[1:0];
    end else if (wr_slow) begin
      slow_en_r   <= req.wdata[poc_pkg::SLOW_EN_BIT];
      slow_trim_r <= req.wdata[5:2];                                 // R10
      slow_div_r  <= req.wdata[1:0];                                 // R15
    end
  end

  // Fast oscillator control; a wake event beats a new suspend
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fast_en_r  <= poc_pkg::RST_FAST_OSC_CTRL[poc_pkg::FAST_EN_BIT]; // R11
      suspend_r  <= poc_pkg::RST_FAST_OSC_CTRL[poc_pkg::FAST_SUSP_BIT];
      fast_div_r <= poc_pkg::RST_FAST_OSC_CTRL[2:0];
      fast_cal_r <= poc_pkg::RST_FAST_OSC_CAL;                       // R14
    end else if (ce) begin
      if (wr_fctl) begin
        fast_en_r  <= req.wdata[poc_pkg::FAST_EN_BIT];               // R11
        fast_div_r <= req.wdata[2:0];                                // R13
      end
      if (wake) suspend_r <= 1'b0;                                   // R16
      else if (suspend_set) suspend_r <= 1'b1;                       // R16
      if (wr_ftrm) fast_cal_r <= req.wdata[6:0];                     // R14
    end
  end

  // Multiplier control; reserved bit is not stored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mult_pwr_r <= poc_pkg::RST_MULT_CTRL[poc_pkg::MULT_PWR_BIT];
      mult_en_r  <= poc_pkg::RST_MULT_CTRL[poc_pkg::MULT_EN_BIT];
      speed_r    <= poc_pkg::RST_MULT_CTRL[4:3];
      adc_sel_r  <= poc_pkg::RST_MULT_CTRL[poc_pkg::MULT_ADC_BIT];
      ref_sel_r  <= poc_pkg::RST_MULT_CTRL[poc_pkg::MULT_REF_BIT];
    end else if (wr_mult) begin
      mult_pwr_r <= req.wdata[poc_pkg::MULT_PWR_BIT];                // R6
      mult_en_r  <= req.wdata[poc_pkg::MULT_EN_BIT];                 // R6
      speed_r    <= req.wdata[4:3];                                  // R3
      adc_sel_r  <= req.wdata[poc_pkg::MULT_ADC_BIT];                // R8
      ref_sel_r  <= req.wdata[poc_pkg::MULT_REF_BIT];                // R18
    end
  end

  // Reference output divider follows the source input, two cycles late
  always_ff @(posedge clk_sys) begin
    if (rst) ref_div_r <= 2'h0;
    else if (ce) ref_div_r <= system_clock_source; // R9
  end

  // ----------------------------------------------------------------------
  // Settling timers
  // ----------------------------------------------------------------------
  poc_settle #(.CYCLES(OSC_START)) u_slow (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .run     (slow_en_r),
    .ready   (slow_ready)                                            // R19
  );
  poc_settle #(.CYCLES(OSC_START)) u_fast (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .run     (fast_run_w),
    .ready   (fast_ready)                                            // R12
  );
  poc_settle #(.CYCLES(MULT_SETTLE)) u_mult (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .run     (mult_run_w),
    .ready   (mult_locked)                                           // R7
  );

  // ----------------------------------------------------------------------
  // Read mux (registered)
  // ----------------------------------------------------------------------
  wire [7:0] rd_slow = {slow_en_r, slow_ready, slow_trim_r, slow_div_r};
  wire [7:0] rd_fctl = {fast_en_r, fast_ready, suspend_r, 2'h0, fast_div_r};
  wire [7:0] rd_ftrm = {1'b0, fast_cal_r};
  wire [7:0] rd_mult = {mult_pwr_r, mult_en_r, mult_locked, speed_r,
                        adc_sel_r, 1'b0, ref_sel_r};                 // R7 R19
  wire [7:0] rd_mux  = hit(req, poc_pkg::OFF_SLOW_OSC_CTRL) ? rd_slow :
                       hit(req, poc_pkg::OFF_FAST_OSC_CTRL) ? rd_fctl :
                       hit(req, poc_pkg::OFF_FAST_OSC_TRIM) ? rd_ftrm :
                       hit(req, poc_pkg::OFF_MULT_CTRL)     ? rd_mult : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (rst) rdata <= 8'h00;
    else if (ce && req.rd) rdata <= rd_mux;
  end

  // ----------------------------------------------------------------------
  // Clock selections and ratios
  // ----------------------------------------------------------------------
  // Pulse generator clock divide from multiplier output
  wire [3:0] pg_div_w = (speed_r == 2'h0) ? 4'h1 :
                        (speed_r == 2'h1) ? 4'h4 : 4'h8;             // R3

  // Missing selected source detection
  wire src_ok = (system_clock_source == 2'(poc_pkg::SRC_SLOW)) ? slow_ready :
                (system_clock_source == 2'(poc_pkg::SRC_MULT)) ? mult_locked :
                (system_clock_source == 2'(poc_pkg::SRC_FAST)) ? fast_ready :
                ext_s2_r;                                            // R17

  // Registered outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      multiplier_run       <= 1'b0;
      multiplier_factor    <= 4'(poc_pkg::MULT_FACTOR);              // R1
      multiplier_ref_select <= 1'b0;
      pulse_gen_speed      <= 2'h0;
      pulse_gen_div        <= 4'h1;
      sys_from_mult_div    <= 3'h4;
      loop_adc_div         <= 4'h1;
      ref_out_divider      <= 2'h0;
      ref_out_div_ratio    <= 4'h1;
      fast_osc_run         <= 1'b0;
      fast_osc_calibration <= poc_pkg::RST_FAST_OSC_CAL;
      fast_osc_div_ratio   <= 8'h80;
      slow_osc_run         <= 1'b0;
      slow_osc_trim        <= 4'h0;
      slow_osc_div_ratio   <= 4'h1;
      power_ctrl_clock_ok  <= 1'b0;
      missing_clock_reset  <= 1'b0;
    end else if (ce) begin
      multiplier_run       <= mult_run_w;                            // R6
      multiplier_factor    <= 4'(poc_pkg::MULT_FACTOR);              // R1
      multiplier_ref_select <= ref_sel_r;                            // R18
      pulse_gen_speed      <= speed_r;                               // R3
      pulse_gen_div        <= pg_div_w;                              // R3
      sys_from_mult_div    <= 3'(poc_pkg::SYS_DIV_FROM_PLL);         // R2
      loop_adc_div         <= adc_sel_r ? 4'h8 : 4'h4;               // R8
      ref_out_divider      <= ref_div_r;                             // R9
      ref_out_div_ratio    <= 4'h1 << ref_div_r;                     // R9
      fast_osc_run         <= fast_run_w;                            // R11
      fast_osc_calibration <= fast_cal_r;                            // R14
      fast_osc_div_ratio   <= 8'h80 >> fast_div_r;                   // R13
      slow_osc_run         <= slow_en_r;
      slow_osc_trim        <= slow_trim_r;                           // R10
      slow_osc_div_ratio   <= 4'h8 >> slow_div_r;                    // R15
      power_ctrl_clock_ok  <= mult_locked;                           // R5
      missing_clock_reset  <= missing_det_enable && !src_ok;         // R17
    end
  end

endmodule // poc_clock_ctrl
`default_nettype wire

// ==== hdl/pll_osc_pkg.sv ====
// Package with register map, field layout, reset values and timing counts
package poc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_SLOW_OSC_CTRL = 8'h9c;
  localparam logic [7:0] OFF_FAST_OSC_CTRL = 8'hb2;
  localparam logic [7:0] OFF_FAST_OSC_TRIM = 8'hb3;
  localparam logic [7:0] OFF_MULT_CTRL     = 8'hb9;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_SLOW_OSC_CTRL = 8'hc3;
  localparam logic [7:0] RST_FAST_OSC_CTRL = 8'h00;
  localparam logic [6:0] RST_FAST_OSC_CAL  = 7'h40; // Arbitrary stand-in trim
  localparam logic [7:0] RST_MULT_CTRL     = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int SLOW_EN_BIT    = 7;
  localparam int SLOW_RDY_BIT   = 6;
  localparam int SLOW_TRIM_LSB  = 2;
  localparam int FAST_EN_BIT    = 7;
  localparam int FAST_RDY_BIT   = 6;
  localparam int FAST_SUSP_BIT  = 5;
  localparam int MULT_PWR_BIT   = 7;
  localparam int MULT_EN_BIT    = 6;
  localparam int MULT_LCK_BIT   = 5;
  localparam int MULT_SPD_LSB   = 3;
  localparam int MULT_ADC_BIT   = 2;
  localparam int MULT_RSV_BIT   = 1;
  localparam int MULT_REF_BIT   = 0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ          = 25;
  localparam int MULT_SETTLE_US   = 30;
  localparam int OSC_START_US     = 100;
  localparam int MULT_SETTLE_CYC  = MULT_SETTLE_US * CLK_MHZ;
  localparam int OSC_START_CYC    = OSC_START_US * CLK_MHZ;
  localparam int MULT_FACTOR      = 8;
  localparam int SYS_DIV_FROM_PLL = 4;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SPD_FULL,
    SPD_HALF,
    SPD_QTR_A,
    SPD_QTR_B
  } poc_speed_e;

  typedef enum logic [1:0] {
    SRC_SLOW,
    SRC_MULT,
    SRC_FAST,
    SRC_EXT
  } poc_src_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } poc_req_s;

  typedef struct packed {
    logic       mult_run;
    logic       mult_locked;
    logic       fast_run;
    logic       fast_ready;
    logic       slow_run;
    logic       slow_ready;
  } poc_stat_s;

endpackage

// ==== hdl/poc_settle.sv ====
// Settling timer: counts run time before a ready flag rises
`timescale 1ns/10ps
`default_nettype none
module poc_settle #(
  parameter int CYCLES = 750
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic run,
  output var  logic ready
);

  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_r;
  wire           done = (cnt_r == CW'(CYCLES));

  // Count while running, restart when stopped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= '0;
      ready <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_r <= '0;
        ready <= 1'b0;
      end else begin
        if (!done) cnt_r <= cnt_r + CW'(1);
        ready <= done;
      end
    end
  end

endmodule // poc_settle
`default_nettype wire

// ==== testbench/poc_clock_ctrl_asserts.sv ====
// Concurrent checks on the clock control block's ports
`timescale 1ns/10ps
`default_nettype none
module poc_clock_chk #(
  parameter int MULT_SETTLE = 4
) (
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              ce,
  input wire poc_pkg::poc_req_s req,
  input wire logic [7:0]        rdata,
  input wire logic              missing_det_enable,
  input wire logic              multiplier_run,
  input wire logic [3:0]        multiplier_factor,
  input wire logic [1:0]        pulse_gen_speed,
  input wire logic [3:0]        pulse_gen_div,
  input wire logic [2:0]        sys_from_mult_div,
  input wire logic [3:0]        loop_adc_div,
  input wire logic [1:0]        ref_out_divider,
  input wire logic [3:0]        ref_out_div_ratio,
  input wire logic [7:0]        fast_osc_div_ratio,
  input wire logic [3:0]        slow_osc_div_ratio,
  input wire logic              power_ctrl_clock_ok,
  input wire logic              missing_clock_reset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Run length of the multiplier, for the settling checks
  logic [7:0] run_cnt_r;
  always_ff @(posedge clk_sys) begin
    if (rst || !multiplier_run) run_cnt_r <= 8'h00;
    else if (ce && run_cnt_r != 8'hff) run_cnt_r <= run_cnt_r + 8'h01;
  end

  // ----------------------------------------------------------------------
  // Register write followed by a running cycle
  // ----------------------------------------------------------------------
  sequence s_wr(logic [7:0] a);
    ce && req.wr && req.addr == a ##1 ce;
  endsequence

  a_factor_const: assert property (
    multiplier_factor == 4'h8 && sys_from_mult_div == 3'h4)
    else $error("Multiplier factor or system divider wrong");
  a_mult_needs_both: assert property (
    ce && req.wr && req.addr == poc_pkg::OFF_MULT_CTRL && req.wdata[7:6] != 2'b11 ##1 ce
    |=> !multiplier_run)
    else $error("Multiplier runs without power and enable");
  a_lock_rise_late: assert property (
    $rose(power_ctrl_clock_ok) |-> run_cnt_r >= MULT_SETTLE && run_cnt_r <= MULT_SETTLE + 3)
    else $error("Lock rose at wrong time");
  a_lock_must_come: assert property (
    run_cnt_r == MULT_SETTLE + 4 |-> power_ctrl_clock_ok)
    else $error("Lock missing after settling");
  a_speed_div: assert property (
    pulse_gen_div == (pulse_gen_speed == 2'b00 ? 4'h1 : pulse_gen_speed == 2'b01 ? 4'h4 : 4'h8))
    else $error("Pulse generator divider wrong");
  a_adc_speed: assert property (
    s_wr(poc_pkg::OFF_MULT_CTRL) |=> loop_adc_div == ($past(req.wdata[2], 2) ? 4'h8 : 4'h4))
    else $error("ADC divider wrong");
  a_ref_out_ratio: assert property (
    ref_out_div_ratio == 4'h1 << ref_out_divider)
    else $error("Reference output ratio wrong");
  a_fast_div: assert property (
    s_wr(poc_pkg::OFF_FAST_OSC_CTRL) |=> fast_osc_div_ratio == 8'h80 >> $past(req.wdata[2:0], 2))
    else $error("Fast divider ratio wrong");
  a_slow_div: assert property (
    s_wr(poc_pkg::OFF_SLOW_OSC_CTRL) |=> slow_osc_div_ratio == 4'h8 >> $past(req.wdata[1:0], 2))
    else $error("Slow divider ratio wrong");
  a_missing_off: assert property (
    !missing_det_enable ##1 !missing_det_enable |-> !missing_clock_reset)
    else $error("Missing clock reset while detector off");
  a_reserved_zero: assert property (
    ce && req.rd && req.addr == poc_pkg::OFF_MULT_CTRL |=> !rdata[1])
    else $error("Reserved bit reads one");
endmodule // poc_clock_chk

bind poc_clock_ctrl poc_clock_chk #(.MULT_SETTLE(MULT_SETTLE)) u_chk (
  .clk_sys, .rst, .ce, .req, .rdata, .missing_det_enable, .multiplier_run,
  .multiplier_factor, .pulse_gen_speed, .pulse_gen_div, .sys_from_mult_div, .loop_adc_div,
  .ref_out_divider, .ref_out_div_ratio, .fast_osc_div_ratio, .slow_osc_div_ratio,
  .power_ctrl_clock_ok, .missing_clock_reset
);
`default_nettype wire

// ==== testbench/pll_and_oscillator_control_tb_top.sv ====
// Self-checking bench for the clock control block
`timescale 1ns/10ps
`default_nettype none
module pll_and_oscillator_control_tb_top;
  logic              clk_sys, rst, ce, missing_det_enable, ext_clock_present;
  logic              cmp_enabled, cmp_out, uart_rx, multiplier_run, multiplier_ref_select;
  logic              fast_osc_run, slow_osc_run, power_ctrl_clock_ok, missing_clock_reset;
  logic [1:0]        system_clock_source, pulse_gen_speed, ref_out_divider;
  logic [2:0]        sys_from_mult_div;
  logic [3:0]        multiplier_factor, pulse_gen_div, loop_adc_div, ref_out_div_ratio;
  logic [3:0]        slow_osc_trim, slow_osc_div_ratio;
  logic [6:0]        fast_osc_calibration;
  logic [7:0]        rdata, fast_osc_div_ratio;
  poc_pkg::poc_req_s req;
  int                n_mismatch, compares, cyc;

  // Settling counts shortened for simulation
  poc_clock_ctrl #(.MULT_SETTLE(4), .OSC_START(4)) uut (
    .clk_sys, .rst, .ce, .req, .rdata, .system_clock_source, .missing_det_enable,
    .ext_clock_present, .cmp_enabled, .cmp_out, .uart_rx, .multiplier_run,
    .multiplier_factor, .multiplier_ref_select, .pulse_gen_speed, .pulse_gen_div,
    .sys_from_mult_div, .loop_adc_div, .ref_out_divider, .ref_out_div_ratio, .fast_osc_run,
    .fast_osc_calibration, .fast_osc_div_ratio, .slow_osc_run, .slow_osc_trim,
    .slow_osc_div_ratio, .power_ctrl_clock_ok, .missing_clock_reset
  );

  // ----------------------------------------------------------------------
  // Clock, timeout and helper tasks
  // ----------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic wrap_up;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    tick(1);
    req.wr = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req.addr = a;
    req.rd = 1'b1;
    tick(1);
    req.rd = 1'b0;
    tick(1);
    chk(rdata, exp);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    req = '0;
    rst = 1'b1;
    ce = 1'b1;
    system_clock_source = 2'h0;
    missing_det_enable = 1'b0;
    ext_clock_present = 1'b1;
    cmp_enabled = 1'b0;
    cmp_out = 1'b1;
    uart_rx = 1'b1;
    tick(3);
    rst = 1'b0;
    // Reset values and an unmapped place
    tick(10);
    rd(poc_pkg::OFF_SLOW_OSC_CTRL, 8'hc3);
    rd(poc_pkg::OFF_FAST_OSC_CTRL, 8'h00);
    rd(poc_pkg::OFF_FAST_OSC_TRIM, 8'h40);
    rd(poc_pkg::OFF_MULT_CTRL, 8'h00);
    rd(8'ha0, 8'h00);
    // Multiplier with only one of power and enable
    wr(poc_pkg::OFF_MULT_CTRL, 8'h41);
    tick(12);
    chk(multiplier_run, 1'b0);
    wr(poc_pkg::OFF_MULT_CTRL, 8'h81);
    tick(12);
    rd(poc_pkg::OFF_MULT_CTRL, 8'h81);
    // Both bits, external reference, reserved bit kept zero
    wr(poc_pkg::OFF_MULT_CTRL, 8'hc1);
    rd(poc_pkg::OFF_MULT_CTRL, 8'hc1);
    tick(12);
    rd(poc_pkg::OFF_MULT_CTRL, 8'he1);
    chk(power_ctrl_clock_ok, 1'b1);
    chk(multiplier_ref_select, 1'b1);
    chk(multiplier_factor, 8'h08);
    chk(sys_from_mult_div, 8'h04);
    ext_clock_present = 1'b0;
    tick(8);
    chk(multiplier_run, 1'b0);
    ext_clock_present = 1'b1;
    // Pulse speed and ADC speed codes
    for (int i = 0; i < 4; i++) begin
      wr(poc_pkg::OFF_MULT_CTRL, 8'hc1 | 8'(i << 3) | (i[0] ? 8'h04 : 8'h00));
      tick(2);
      chk(pulse_gen_speed, 8'(i));
      chk(pulse_gen_div, (i == 0) ? 8'h01 : (i == 1) ? 8'h04 : 8'h08);
      chk(loop_adc_div, i[0] ? 8'h08 : 8'h04);
    end
    // Internal reference and fast divider codes
    wr(poc_pkg::OFF_FAST_OSC_CTRL, 8'h87);
    wr(poc_pkg::OFF_MULT_CTRL, 8'hc0);
    tick(14);
    chk(multiplier_ref_select, 1'b0);
    chk(power_ctrl_clock_ok, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wr(poc_pkg::OFF_FAST_OSC_CTRL, 8'h80 | 8'(i));
      tick(2);
      chk(fast_osc_div_ratio, 8'h80 >> i);
      chk(fast_osc_run, 1'b1);
    end
    wr(poc_pkg::OFF_FAST_OSC_CTRL, 8'h9f);
    tick(8);
    rd(poc_pkg::OFF_FAST_OSC_CTRL, 8'hc7);
    // Suspend, woken by receive edge and then by comparator
    wr(poc_pkg::OFF_FAST_OSC_CTRL, 8'ha7);
    tick(2);
    chk(fast_osc_run, 1'b0);
    uart_rx = 1'b0;
    tick(6);
    chk(fast_osc_run, 1'b1);
    uart_rx = 1'b1;
    tick(8);
    rd(poc_pkg::OFF_FAST_OSC_CTRL, 8'hc7);
    wr(poc_pkg::OFF_FAST_OSC_CTRL, 8'ha7);
    cmp_out = 1'b0;
    tick(6);
    chk(fast_osc_run, 1'b0);
    cmp_enabled = 1'b1;
    tick(6);
    chk(fast_osc_run, 1'b1);
    cmp_out = 1'b1;
    cmp_enabled = 1'b0;
    wr(poc_pkg::OFF_FAST_OSC_CTRL, 8'h07);
    tick(8);
    chk(fast_osc_run, 1'b0);
    rd(poc_pkg::OFF_FAST_OSC_CTRL, 8'h07);
    // Calibration field
    wr(poc_pkg::OFF_FAST_OSC_TRIM, 8'hff);
    rd(poc_pkg::OFF_FAST_OSC_TRIM, 8'h7f);
    chk(fast_osc_calibration, 8'h7f);
    wr(poc_pkg::OFF_FAST_OSC_TRIM, 8'h00);
    tick(2);
    chk(fast_osc_calibration, 8'h00);
    // Slow oscillator trim and divider
    for (int i = 0; i < 4; i++) begin
      wr(poc_pkg::OFF_SLOW_OSC_CTRL, 8'h80 | 8'(i * 20) | 8'(i));
      tick(2);
      chk(slow_osc_div_ratio, 8'h08 >> i);
      chk(slow_osc_trim, 8'(i * 5));
    end
    wr(poc_pkg::OFF_SLOW_OSC_CTRL, 8'h03);
    tick(8);
    chk(slow_osc_run, 1'b0);
    rd(poc_pkg::OFF_SLOW_OSC_CTRL, 8'h03);
    // Missing clock with multiplier selected but unlocked
    system_clock_source = 2'h1;
    missing_det_enable = 1'b1;
    tick(6);
    chk(missing_clock_reset, 1'b1);
    missing_det_enable = 1'b0;
    system_clock_source = 2'h2;
    tick(4);
    chk(missing_clock_reset, 1'b0);
    chk(ref_out_divider, 8'h02);
    chk(ref_out_div_ratio, 8'h04);
    // Writes ignored while frozen
    ce = 1'b0;
    wr(poc_pkg::OFF_FAST_OSC_TRIM, 8'h55);
    ce = 1'b1;
    rd(poc_pkg::OFF_FAST_OSC_TRIM, 8'h00);
    wrap_up();
  end
endmodule // pll_and_oscillator_control_tb_top
`default_nettype wire
